// *** common/eie_pkg.sv ***
// Purpose: Shared constants and types for the escape instruction unit
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Opcode values are second bytes following the escape byte
package eie_pkg;

  // Escape byte and extended opcodes
  localparam logic [7:0] ESC_BYTE = 8'ha5;
  localparam logic [7:0] OP_BREAK = 8'h00;
  localparam logic [7:0] OP_ASR = 8'h03;
  localparam logic [7:0] OP_LSL = 8'h23;
  localparam logic [7:0] OP_JMP_PC = 8'h73;
  localparam logic [7:0] OP_MOV_DP = 8'h90;
  localparam logic [7:0] OP_CODE_BYTE_LOAD = 8'h93;
  localparam logic [7:0] OP_INC_DP = 8'ha3;
  localparam logic [7:0] OP_MAC = 8'ha4;
  localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_R0 = 8'hb6;
  localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_R1 = 8'hb7;
  localparam logic [7:0] OP_EXTERNAL_MOVE_RD = 8'he0;
  localparam logic [7:0] OP_CLR_M = 8'he4;
  localparam logic [7:0] OP_EXTERNAL_MOVE_WR = 8'hf0;

  // Cycle counts, escape byte cycle counted as cycle 1
  localparam logic [3:0] CYC_SHORT = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;
  localparam logic [3:0] CYC_FIVE = 4'h5;
  localparam logic [3:0] CYC_MAC = 4'h9;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;

  // Register byte offsets
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_B = 8'h04;
  localparam logic [7:0] ADDR_AHI = 8'h08;
  localparam logic [7:0] ADDR_BHI = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_DP0 = 8'h14;
  localparam logic [7:0] ADDR_DP1 = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_MLO = 8'h20;
  localparam logic [7:0] ADDR_MHI = 8'h24;
  localparam logic [7:0] ADDR_PC = 8'h28;
  localparam logic [7:0] ADDR_IDX = 8'h2c;
  localparam logic [7:0] ADDR_STAT = 8'h30;

  // Field positions
  localparam int FLAG_CY = 7;
  localparam int FLAG_OV = 2;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_DBG = 1;
  localparam int CTRL_SPACE = 2;
  localparam int STAT_BAD = 4;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [39:0] M_RST = 40'h00_0000_0000;

  typedef enum logic [2:0] {
    EIE_IDLE = 3'b000,
    EIE_OPC = 3'b001,
    EIE_ARG = 3'b011,
    EIE_WAIT = 3'b010,
    EIE_HALT = 3'b110
  } eie_state_t;

  typedef enum logic [1:0] {
    EIE_SP_CODE = 2'h0,
    EIE_SP_EXTRA = 2'h1,
    EIE_SP_FLASH = 2'h2,
    EIE_SP_EXT = 2'h3
  } eie_space_t;

  typedef struct packed {
    logic req;
    logic we;
    eie_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } eie_mem_req_t;

endpackage

// *** hdl/eie_core.sv ***
// Purpose: Decode and execute of escape-prefixed extended instructions
// Assumes: Fetch delivers one byte per cycle; memory acks a held request
// Notes: Architectural state is reachable over APB while idle
// Contract
// - Escape byte A5 prefixes extended opcode
// - Arithmetic right shift keeps bit 39
// - Break enters debug halt, PC next
// - Break without debug: two-cycle no-operation
// - Compare indirect byte, branch if different
// - Carry means accumulator below operand, unsigned
// - Clear accumulator register, flags untouched
// - Alternate pointer increments, three cycles
// - Jump to PC plus two plus A
// - Logical left shift, zero into bit0
// - Code byte from alternate pointer plus A
// - Signed 16x16 product added into accumulator
// - Overflow sticky-set, carry gives result sign
// - Immediate load: high byte then low
// - External read: three or five cycles
// - External write of A via alternate pointer
`timescale 1ns/1ns
`default_nettype none
module eie_core
  import eie_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fetch_valid_in,
  input wire logic [7:0] fetch_byte_in,
  output logic fetch_ready_out,
  output logic [15:0] pc_out,
  output logic [7:0] iram_addr_out,
  input wire logic [7:0] iram_rdata_in,
  output eie_mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic debug_resume_in,
  output logic debug_break_out,
  output logic not_escape_out,
  output logic done_out
);

  eie_state_t state_r;
  logic [7:0] op_r, arg1_r, arg2_r, acc_r, b_r, ahi_r, bhi_r;
  logic [7:0] idx0_r, idx1_r, mdata_r;
  logic [2:0] taken_r;
  logic [3:0] cnt_r;
  logic [15:0] pc_r, dp0_r, dp1_r;
  logic [39:0] m_r;
  logic cy_r, ov_r, sel_r, dbg_en_r, bad_r, memdone_r;
  logic [1:0] xsp_r;

  logic [7:0] op_now, rd_byte;
  logic [2:0] need;
  logic [3:0] ncyc;
  logic [15:0] alt_dp, pc_now, alt_inc;
  logic take, last_byte, is_mem, mem_ok, fire, known;
  logic apb_wr, apb_setup, mapped;
  logic signed [31:0] prod;
  logic [39:0] mac_sum, mac_ext;
  logic [7:0] lo_byte;

  // Opcode in view: live byte while it is being taken
  assign op_now = (state_r == EIE_OPC) ? fetch_byte_in : op_r;
  // unselected pointer
  // Select bit zero means pointer one is the alternate
  assign alt_dp = sel_r ? dp0_r : dp1_r;
  assign alt_inc = alt_dp + 16'h0001;

  // Length, cycle count and memory use per opcode
  always_comb begin
    need = LEN_TWO;
    ncyc = CYC_SHORT;
    is_mem = 1'b0;
    known = 1'b1;
    case (op_now)
      OP_BREAK, OP_ASR, OP_LSL, OP_CLR_M: ncyc = CYC_SHORT;
      OP_INC_DP, OP_JMP_PC: ncyc = CYC_THREE;
      OP_MAC: ncyc = CYC_MAC;
      OP_COMPARE_JUMP_NOT_EQUAL_R0, OP_COMPARE_JUMP_NOT_EQUAL_R1: begin
        need = LEN_THREE;
        ncyc = CYC_FOUR;
      end
      OP_MOV_DP: begin
        need = LEN_FOUR;
        ncyc = CYC_FOUR;
      end
      OP_CODE_BYTE_LOAD: begin
        ncyc = CYC_FOUR;
        is_mem = 1'b1;
      end
      OP_EXTERNAL_MOVE_RD, OP_EXTERNAL_MOVE_WR: begin
        ncyc = (xsp_r == 2'h0) ? CYC_THREE : CYC_FIVE;
        is_mem = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  // Byte acceptance and completion
  assign fetch_ready_out = (state_r == EIE_IDLE) || (state_r == EIE_OPC)
    || (state_r == EIE_ARG);
  assign take = fetch_valid_in && fetch_ready_out;
  assign last_byte = take && (state_r != EIE_IDLE) && (taken_r + 3'h1 == need);
  assign mem_ok = !is_mem || memdone_r || (mem_out.req && mem_ack_in);
  assign fire = (last_byte || state_r == EIE_WAIT) && (cnt_r >= ncyc)
    && mem_ok;
  assign pc_now = take ? pc_r + 16'h0001 : pc_r;
  assign rd_byte = memdone_r ? mdata_r : mem_rdata_in;
  assign lo_byte = (state_r == EIE_ARG) ? fetch_byte_in : arg2_r;

  assign prod = $signed({ahi_r, acc_r}) * $signed({bhi_r, b_r});
  assign mac_ext = {{8{prod[31]}}, prod};
  assign mac_sum = m_r + mac_ext;

  // Sequencer
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= EIE_IDLE;
    end else begin
      case (state_r)
        EIE_IDLE: begin
          if (take && fetch_byte_in == ESC_BYTE) begin
            state_r <= EIE_OPC;
          end
        end
        EIE_OPC, EIE_ARG, EIE_WAIT: begin
          if (fire) begin
            state_r <= (op_now == OP_BREAK && dbg_en_r) ? EIE_HALT
              : EIE_IDLE;
          end else if (last_byte) begin
            state_r <= EIE_WAIT;
          end else if (take) begin
            state_r <= EIE_ARG;
          end
        end
        EIE_HALT: begin
          if (debug_resume_in) begin
            state_r <= EIE_IDLE;
          end
        end
        default: state_r <= EIE_IDLE;
      endcase
    end
  end

  // Instruction bytes and cycle count
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_r <= 8'h00;
      arg1_r <= 8'h00;
      arg2_r <= 8'h00;
      taken_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      if (state_r == EIE_IDLE) begin
        taken_r <= 3'h1;
        cnt_r <= 4'h2;
      end else if (cnt_r != 4'hf) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (take && state_r != EIE_IDLE) begin
        taken_r <= taken_r + 3'h1;
        if (state_r == EIE_OPC) begin
          op_r <= fetch_byte_in;
        end else if (taken_r == 3'h2) begin
          arg1_r <= fetch_byte_in;
        end else begin
          arg2_r <= fetch_byte_in;
        end
      end
    end
  end

  // Memory request held until acknowledged; a late ack stretches cycles
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_out <= '0;
      memdone_r <= 1'b0;
      mdata_r <= 8'h00;
      iram_addr_out <= 8'h00;
    end else begin
      if (state_r == EIE_IDLE) begin
        memdone_r <= 1'b0;
      end
      if (mem_out.req && mem_ack_in) begin
        mem_out.req <= 1'b0;
        memdone_r <= 1'b1;
        mdata_r <= mem_rdata_in;
      end else if (last_byte && is_mem && !fire) begin
        mem_out.req <= 1'b1;
        mem_out.we <= (op_now == OP_EXTERNAL_MOVE_WR);
        mem_out.addr <= (op_now == OP_CODE_BYTE_LOAD) ? alt_dp + {8'h00, acc_r}
          : alt_dp;
        mem_out.space <= (op_now == OP_CODE_BYTE_LOAD) ? EIE_SP_CODE
          : (xsp_r == 2'h0) ? EIE_SP_EXTRA
          : (xsp_r == 2'h1) ? EIE_SP_FLASH : EIE_SP_EXT;
        mem_out.wdata <= acc_r;
      end
      if (state_r == EIE_OPC && take) begin
        iram_addr_out <= fetch_byte_in[0] ? idx1_r : idx0_r;
      end
    end
  end

  // Program counter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_r <= PC_RST;
    end else if (apb_wr && paddr_in == ADDR_PC && state_r == EIE_IDLE) begin
      pc_r <= pwdata_in[15:0];
    end else if (fire && op_now == OP_JMP_PC) begin
      pc_r <= pc_now + {8'h00, acc_r};
    end else if (fire && (op_now == OP_COMPARE_JUMP_NOT_EQUAL_R0 || op_now == OP_COMPARE_JUMP_NOT_EQUAL_R1)
                 && acc_r != iram_rdata_in) begin
      pc_r <= pc_now + {{8{arg1_r[7]}}, arg1_r};
    end else begin
      pc_r <= pc_now;
    end
  end

  // MAC accumulator
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      m_r <= M_RST;
    end else if (fire) begin
      case (op_now)
        OP_ASR: m_r <= {m_r[39], m_r[39:1]};
        OP_LSL: m_r <= {m_r[38:0], 1'b0};
        OP_CLR_M: m_r <= M_RST;
        OP_MAC: m_r <= mac_sum;
        default: m_r <= m_r;
      endcase
    end else if (apb_wr && state_r == EIE_IDLE) begin
      if (paddr_in == ADDR_MLO) begin
        m_r[31:0] <= pwdata_in;
      end else if (paddr_in == ADDR_MHI) begin
        m_r[39:32] <= pwdata_in[7:0];
      end
    end
  end

  // Flags
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cy_r <= 1'b0;
      ov_r <= 1'b0;
    end else if (fire && (op_now == OP_COMPARE_JUMP_NOT_EQUAL_R0 || op_now == OP_COMPARE_JUMP_NOT_EQUAL_R1)) begin
      cy_r <= acc_r < iram_rdata_in;
    end else if (fire && op_now == OP_MAC) begin
      cy_r <= mac_sum[39];
      if (m_r[39] == mac_ext[39] && mac_sum[39] != m_r[39]) begin
        ov_r <= 1'b1;
      end
    end else if (apb_wr && paddr_in == ADDR_FLAGS && state_r == EIE_IDLE) begin
      cy_r <= pwdata_in[FLAG_CY];
      ov_r <= pwdata_in[FLAG_OV];
    end
  end

  // Accumulator and operand registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r <= 8'h00;
      b_r <= 8'h00;
      ahi_r <= 8'h00;
      bhi_r <= 8'h00;
      idx0_r <= 8'h00;
      idx1_r <= 8'h00;
    end else if (fire && (op_now == OP_CODE_BYTE_LOAD || op_now == OP_EXTERNAL_MOVE_RD)) begin
      acc_r <= rd_byte;
    end else if (apb_wr && state_r == EIE_IDLE) begin
      case (paddr_in)
        ADDR_ACC: acc_r <= pwdata_in[7:0];
        ADDR_B: b_r <= pwdata_in[7:0];
        ADDR_AHI: ahi_r <= pwdata_in[7:0];
        ADDR_BHI: bhi_r <= pwdata_in[7:0];
        ADDR_IDX: begin
          idx0_r <= pwdata_in[7:0];
          idx1_r <= pwdata_in[15:8];
        end
        default: acc_r <= acc_r;
      endcase
    end
  end

  // Data pointers and control
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dp0_r <= 16'h0000;
      dp1_r <= 16'h0000;
      sel_r <= 1'b0;
      dbg_en_r <= 1'b0;
      xsp_r <= 2'h0;
    end else if (fire && (op_now == OP_INC_DP || op_now == OP_MOV_DP)) begin
      if (sel_r) begin
        dp0_r <= (op_now == OP_INC_DP) ? alt_inc : {arg1_r, lo_byte};
      end else begin
        dp1_r <= (op_now == OP_INC_DP) ? alt_inc : {arg1_r, lo_byte};
      end
    end else if (apb_wr && state_r == EIE_IDLE) begin
      if (paddr_in == ADDR_DP0) begin
        dp0_r <= pwdata_in[15:0];
      end else if (paddr_in == ADDR_DP1) begin
        dp1_r <= pwdata_in[15:0];
      end else if (paddr_in == ADDR_CTRL) begin
        sel_r <= pwdata_in[CTRL_SEL];
        dbg_en_r <= pwdata_in[CTRL_DBG];
        xsp_r <= pwdata_in[CTRL_SPACE+1:CTRL_SPACE];
      end
    end
  end

  // Event pulses; unknown opcode sets a sticky flag, set beats clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      debug_break_out <= 1'b0;
      not_escape_out <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      done_out <= fire;
      debug_break_out <= fire && op_now == OP_BREAK && dbg_en_r;
      not_escape_out <= take && state_r == EIE_IDLE
        && fetch_byte_in != ESC_BYTE;
      if (fire && !known) begin
        bad_r <= 1'b1;
      end else if (apb_wr && paddr_in == ADDR_STAT
                   && pwdata_in[STAT_BAD]) begin
        bad_r <= 1'b0;
      end
    end
  end

  // APB slave: zero wait states, read data captured in setup phase
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_setup = psel_in && !penable_in;
  assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= ADDR_STAT);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign pc_out = pc_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_setup) begin
      case (paddr_in)
        ADDR_ACC: prdata_out <= {24'h000000, acc_r};
        ADDR_B: prdata_out <= {24'h000000, b_r};
        ADDR_AHI: prdata_out <= {24'h000000, ahi_r};
        ADDR_BHI: prdata_out <= {24'h000000, bhi_r};
        ADDR_FLAGS: prdata_out <= {24'h000000, cy_r, 4'h0, ov_r, 2'h0};
        ADDR_DP0: prdata_out <= {16'h0000, dp0_r};
        ADDR_DP1: prdata_out <= {16'h0000, dp1_r};
        ADDR_CTRL: prdata_out <= {28'h0000000, xsp_r, dbg_en_r, sel_r};
        ADDR_MLO: prdata_out <= m_r[31:0];
        ADDR_MHI: prdata_out <= {24'h000000, m_r[39:32]};
        ADDR_PC: prdata_out <= {16'h0000, pc_r};
        ADDR_IDX: prdata_out <= {16'h0000, idx1_r, idx0_r};
        ADDR_STAT: prdata_out <= {27'h0000000, bad_r, 1'b0, state_r};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** sim/eie_core_properties.sv ***
// Purpose: Port timing checks for the escape instruction unit
// Assumes: Escape byte is cycle one; memory request held until ack
// Notes: Bound into every eie_core instance
`timescale 1ns/1ns
`default_nettype none
module eie_core_properties
  import eie_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic fetch_valid_in,
  input wire logic fetch_ready_out,
  input wire logic [7:0] fetch_byte_in,
  input wire logic [15:0] pc_out,
  input wire eie_mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Byte handed over at this edge
  wire logic take = fetch_valid_in && fetch_ready_out;
  // Escape then extended opcode
  sequence s_op(logic [7:0] op);
    take && fetch_byte_in == ESC_BYTE ##1 take && fetch_byte_in == op;
  endsequence
  // Busy one cycle, then done
  sequence s_fin;
    !fetch_ready_out ##1 done_out;
  endsequence
  property p_asr;
    s_op(OP_ASR) |=> done_out;
  endproperty
  a_asr: assert property (p_asr) else $error("shift late");
  property p_clr;
    s_op(OP_CLR_M) |=> done_out;
  endproperty
  a_clr: assert property (p_clr) else $error("clear late");
  property p_inc;
    s_op(OP_INC_DP) |=> s_fin;
  endproperty
  a_inc: assert property (p_inc) else $error("inc timing");
  property p_jmp;
    s_op(OP_JMP_PC) |=> s_fin;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump timing");
  property p_mac;
    s_op(OP_MAC) |=> !fetch_ready_out [*7] ##1 done_out;
  endproperty
  a_mac: assert property (p_mac) else $error("mac timing");
  property p_compare_jump_not_equal;
    s_op(OP_COMPARE_JUMP_NOT_EQUAL_R0) ##1 take |=> s_fin;
  endproperty
  a_compare_jump_not_equal: assert property (p_compare_jump_not_equal) else $error("compare_jump_not_equal timing");
  property p_pc;
    take |=> pc_out == $past(pc_out) + 16'h1;
  endproperty
  a_pc: assert property (p_pc) else $error("pc step wrong");
  property p_hold;
    mem_out.req && !mem_ack_in |=>
      mem_out.req && $stable(mem_out.addr) && $stable(mem_out.we);
  endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
endmodule
bind eie_core eie_core_properties eie_core_properties_i (.*);
`default_nettype wire

// *** sim/escape_instruction_extensions_bench.sv ***
// Purpose: Self-checking bench for the escape instruction unit
// Assumes: Memory and internal RAM answer from address functions
// Notes: Bench model is read back over APB after each step
`timescale 1ns/1ns
`default_nettype none
module escape_instruction_extensions_bench
  import eie_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, fv = 1'h0, dres = 1'h0;
  logic go = 1'h1, slow = 1'h0, lw, le, mcy, mov, sel, dbg, mack;
  logic [7:0] paddr = 8'h00, fb = 8'h00, rs = 8'h50, rg = 8'h50;
  logic [7:0] ma, mb, mah, mbh, iaddr, mrd, ld;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic prdy, perr, frdy, dbrk, nesc, done;
  logic [15:0] pc, mpc, midx, la, md [2];
  logic [39:0] mm;
  logic [1:0] cs;
  eie_space_t ls;
  eie_mem_req_t mreq;
  int fail_count = 0, checks_done = 0, ncyc = 0, tq;

  eie_core eie_core_i (.clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy),
    .pslverr_out(perr), .fetch_valid_in(fv), .fetch_byte_in(fb),
    .fetch_ready_out(frdy), .pc_out(pc), .iram_addr_out(iaddr),
    .iram_rdata_in(iaddr ^ 8'h5a), .mem_out(mreq), .mem_ack_in(mack),
    .mem_rdata_in(mrd), .debug_resume_in(dres), .debug_break_out(dbrk),
    .not_escape_out(nesc), .done_out(done));

  always #50 clk = ~clk;
  function automatic logic [7:0] mf(logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] lf(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function logic [7:0] rnd();
    rs = lf(rs);
    return rs;
  endfunction
  function eie_space_t sp();
    return cs == 2'h0 ? EIE_SP_EXTRA : cs == 2'h1 ? EIE_SP_FLASH : EIE_SP_EXT;
  endfunction
  // Ack at once, or on random cycles when slow
  assign mack = mreq.req & go;
  // Bus shows inverted data when not acked
  assign mrd = mack ? mf(mreq.addr) : ~mf(mreq.addr);
  // Cycle count, memory capture, hang guard
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    rg <= lf(rg);
    go <= slow ? rg[0] : 1'h1;
    if (mack) begin
      la <= mreq.addr;
      ld <= mreq.wdata;
      lw <= mreq.we;
      ls <= mreq.space;
    end
    if (ncyc == 30000) begin
      fail_count++;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(logic [39:0] g, logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer, zero or more wait states
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (prdy !== 1'h1) @(posedge clk);
    rd = prdata;
    le = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task xr(logic w, logic [7:0] a, logic [31:0] d);
    apb(w, a, d);
    if (!w) chk(40'({le, rd}), 40'({1'h0, d}));
  endtask
  // Load model into design, or compare design with it
  task regs(logic w);
    xr(w, ADDR_ACC, 32'(ma));
    xr(w, ADDR_B, 32'(mb));
    xr(w, ADDR_AHI, 32'(mah));
    xr(w, ADDR_BHI, 32'(mbh));
    xr(w, ADDR_MLO, mm[31:0]);
    xr(w, ADDR_MHI, 32'(mm[39:32]));
    xr(w, ADDR_DP0, 32'(md[0]));
    xr(w, ADDR_DP1, 32'(md[1]));
    xr(w, ADDR_CTRL, 32'({cs, dbg, sel}));
    xr(w, ADDR_IDX, 32'(midx));
    xr(w, ADDR_FLAGS, 32'({mcy, 4'h0, mov, 2'h0}));
    xr(w, ADDR_PC, 32'(mpc));
  endtask
  task fbyte(logic [7:0] b);
    fv <= 1'h1;
    fb <= b;
    @(negedge clk);
    while (frdy !== 1'h1) @(negedge clk);
    tq = ncyc;
    @(posedge clk);
  endtask
  // Run one extended instruction and its model
  task ins(logic [7:0] op, logic [7:0] x = 8'h00, logic [7:0] y = 8'h00);
    int s;
    int n;
    logic [15:0] ap;
    logic [7:0] iv;
    logic [39:0] p;
    logic [39:0] t;
    ap = md[~sel];
    iv = (op[0] ? midx[15:8] : midx[7:0]) ^ 8'h5a;
    fbyte(ESC_BYTE);
    s = tq;
    fbyte(op);
    mpc = mpc + 16'h2;
    if (op[7:1] == 7'h5b || op == OP_MOV_DP) begin
      fbyte(x);
      mpc = mpc + 16'h1;
    end
    if (op == OP_MOV_DP) begin
      fbyte(y);
      mpc = mpc + 16'h1;
    end
    fv <= 1'h0;
    case (op)
      OP_INC_DP, OP_JMP_PC: n = 3;
      OP_MOV_DP, OP_CODE_BYTE_LOAD, OP_COMPARE_JUMP_NOT_EQUAL_R0, OP_COMPARE_JUMP_NOT_EQUAL_R1: n = 4;
      OP_MAC: n = 9;
      OP_EXTERNAL_MOVE_RD, OP_EXTERNAL_MOVE_WR: n = cs == 2'h0 ? 3 : 5;
      default: n = 2;
    endcase
    case (op)
      OP_ASR: mm = {mm[39], mm[39:1]};
      OP_LSL: mm = {mm[38:0], 1'h0};
      OP_CLR_M: mm = 40'h0;
      OP_INC_DP: md[~sel] = ap + 16'h1;
      OP_JMP_PC: mpc = mpc + 16'(ma);
      OP_MOV_DP: md[~sel] = {x, y};
      OP_CODE_BYTE_LOAD: ma = mf(ap + 16'(ma));
      OP_EXTERNAL_MOVE_RD: ma = mf(ap);
      OP_MAC: begin
        p = $signed({mah, ma}) * $signed({mbh, mb});
        t = mm + p;
        if (mm[39] == p[39] && t[39] != mm[39]) mov = 1'h1;
        mcy = t[39];
        mm = t;
      end
      OP_COMPARE_JUMP_NOT_EQUAL_R0, OP_COMPARE_JUMP_NOT_EQUAL_R1: begin
        mcy = ma < iv;
        if (ma != iv) mpc = mpc + {{8{x[7]}}, x};
      end
      default: ;
    endcase
    if (op == OP_BREAK && dbg) return;
    @(negedge clk);
    while (done !== 1'h1) @(negedge clk);
    if (!slow) chk(40'(ncyc - s), 40'(n));
    chk(40'(pc), 40'(mpc));
    @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    chk(40'(pc), 40'h0);
    chk(40'(mreq), 40'h0);
    rst_n <= 1'h1;
    {ma, mb, mah, mbh} = 32'h3421_0102;
    mm = 40'hc5b1a29384;
    md[0] = 16'h0123;
    md[1] = 16'h12fe;
    {mpc, midx} = 32'h0100_7856;
    // Overflow starts clear so the first MAC must set it
    {mcy, mov, sel, dbg, cs} = 6'h00;
    regs(1'h1);
    ins(OP_ASR);
    regs(1'h0);
    mm = 40'hc5b1a29384;
    regs(1'h1);
    ins(OP_LSL);
    regs(1'h0);
    ins(OP_CLR_M);
    regs(1'h0);
    repeat (3) ins(OP_INC_DP);
    regs(1'h0);
    sel = 1'h1;
    md[0] = 16'hffff;
    regs(1'h1);
    ins(OP_INC_DP);
    regs(1'h0);
    ins(OP_MOV_DP, 8'h56, 8'h78);
    regs(1'h0);
    mpc = 16'hfff8;
    ma = 8'hff;
    regs(1'h1);
    ins(OP_JMP_PC);
    regs(1'h0);
    for (int i = 0; i < 4; i++) begin
      midx = {rnd(), rnd()};
      ma = i == 2 ? midx[7:0] ^ 8'h5a : rnd();
      regs(1'h1);
      ins(OP_COMPARE_JUMP_NOT_EQUAL_R0 | {7'h0, i[0]}, rnd());
      regs(1'h0);
    end
    mm = 40'h7fffffff00;
    for (int i = 0; i < 6; i++) begin
      mah = i == 0 ? 8'h7f : rnd();
      mbh = i == 0 ? 8'h7f : rnd();
      ma = rnd();
      mb = rnd();
      if (i == 3) mov = 1'h0;
      regs(1'h1);
      ins(OP_MAC);
      regs(1'h0);
    end
    // code read carries into high byte
    sel = 1'h0;
    md[1] = 16'h10f0;
    ma = 8'h20;
    regs(1'h1);
    ins(OP_CODE_BYTE_LOAD);
    chk(40'({ls, la}), 40'({EIE_SP_CODE, 16'h1110}));
    regs(1'h0);
    for (int i = 0; i < 8; i++) begin
      cs = i[1:0];
      slow = i[2];
      sel = i[0];
      md[~sel] = {rnd(), rnd()};
      regs(1'h1);
      ins(OP_EXTERNAL_MOVE_RD);
      chk(40'({lw, ls, la}), 40'({1'h0, sp(), md[~sel]}));
      ins(OP_EXTERNAL_MOVE_WR);
      chk(40'({lw, ls, la, ld}), 40'({1'h1, sp(), md[~sel], ma}));
      regs(1'h0);
    end
    slow = 1'h0;
    ins(OP_BREAK);
    dbg = 1'h1;
    regs(1'h1);
    ins(OP_BREAK);
    @(negedge clk);
    while (dbrk !== 1'h1) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(40'({frdy, pc}), 40'({1'h0, mpc}));
    @(posedge clk);
    dres <= 1'h1;
    @(posedge clk);
    dres <= 1'h0;
    ins(8'h55);
    regs(1'h0);
    // Unknown opcode leaves the sticky bit; writing one clears it
    xr(1'h0, ADDR_STAT, 32'h10);
    xr(1'h1, ADDR_STAT, 32'h10);
    xr(1'h0, ADDR_STAT, 32'h0);
    // plain byte, never a stray escape
    fbyte(8'h74);
    fv <= 1'h0;
    @(negedge clk);
    mpc = mpc + 16'h1;
    chk(40'({nesc, pc}), 40'({1'h1, mpc}));
    apb(1'h0, 8'h34, 32'h0);
    chk(40'({le, rd}), 40'({1'h1, 32'h0}));
    test_done();
  end
endmodule
`default_nettype wire
